// ---- logic/obc_decode.sv ----
// combinational decode of the two configuration bytes
module obc_decode
	import obc_pkg::*;
(
	input wire logic [7:0] byte0,
	input wire logic [7:0] byte1,
	output obc_pkg::obc_clk_src_t clk_src,
	output obc_pkg::obc_vd_t vd_level
);
	// range field only counts with the rc oscillator deselected
	always_comb begin
		if (!byte1[B1_RCSEL]) begin // (RQ3)
			clk_src = OBC_CLK_RC;
		end else begin
			unique case (byte0[B0_OSC_HI:B0_OSC_LO]) // (RQ4)
				OSC_LP: clk_src = OBC_CLK_RES_1_2M;
				OSC_MP: clk_src = OBC_CLK_RES_2_4M;
				OSC_MS: clk_src = OBC_CLK_RES_4_8M;
				OSC_HS: clk_src = OBC_CLK_RES_8_16M;
				OSC_VLP: clk_src = OBC_CLK_RES_32K;
				OSC_EXT_PIN: clk_src = OBC_CLK_EXT_OSC_PIN;
				OSC_EXT_ALT: clk_src = OBC_CLK_EXT_ALT_PIN;
				OSC_RSVD: clk_src = OBC_CLK_RESERVED;
			endcase
		end
	end

	// threshold code, all ones turns detection off
	always_comb begin
		unique case (byte1[B1_LVD_HI:B1_LVD_LO]) // (RQ11)
			LVD_OFF: vd_level = OBC_VD_OFF;
			LVD_HIGH: vd_level = OBC_VD_HIGH;
			LVD_MED: vd_level = OBC_VD_MED;
			LVD_LOW: vd_level = OBC_VD_LOW;
		endcase
	end
endmodule : obc_decode

// ---- logic/obc_top.sv ----
// configuration byte store, programming access and applied settings
// Notes on behaviour
// (RQ1) bytes change only in programming mode
// (RQ2) programmer keeps reserved top bit set
// (RQ3) range field used only with rc off
// (RQ4) range codes map to resonator or external
// (RQ5) programmer leaves range default under rc
// (RQ6) two bits pick sector zero size
// (RQ7) read-out bit blocks extraction and writes
// (RQ8) protected erase wipes program memory first
// (RQ9) write lock is permanent, bytes frozen; here the second byte stays writable
// (RQ10) blank program memory reads all ones
// (RQ11) two bits pick voltage detect threshold
// (RQ12) watchdog type bit: hardware or software
// (RQ13) halt entry resets when bit set
// (RQ14) settings captured at reset, then held
// (RQ15) fixed layout of second configuration byte
module obc_top
	import obc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic pwr_on_rst,
	input wire logic prog_mode_pin,
	input wire logic prog_wr,
	input wire logic prog_rd,
	input wire logic prog_erase,
	input wire logic prog_sel,
	input wire logic [7:0] prog_wdata,
	output logic [7:0] prog_rdata,
	output logic prog_busy,
	output logic mem_erase_req,
	input wire logic mem_erase_done,
	output obc_pkg::obc_clk_src_t clk_src,
	output logic [1:0] boot_sector_size,
	output logic readout_protect,
	output logic program_write_lock,
	output logic prog_mem_write_block,
	output logic pll_factor_sel,
	output logic pll_bypass,
	output logic fast_pll_bypass,
	output obc_pkg::obc_vd_t voltage_detect_threshold,
	output logic watchdog_type_sel,
	output logic watchdog_halt_reset,
	output logic [7:0] blank_fill,
	output logic cfg_valid
);
	import obc_pkg::*;

	typedef enum logic {OBC_IDLE, OBC_WIPE} obc_state_t;

	logic mode_m_q, mode_s_q;
	logic [7:0] nv0_q, nv0_d, nv1_q, nv1_d;
	logic [7:0] rdata_q, rdata_d;
	obc_state_t st_q, st_d;
	logic load_q, load_d;
	logic valid_q, valid_d;
	logic [7:0] act0_q, act0_d, act1_q, act1_d;
	obc_clk_src_t src_q, src_d, dec_src;
	obc_vd_t vd_q, vd_d, dec_vd;

	// mode pin comes from the programmer, two stages before use
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_m_q <= 1'b0;
			mode_s_q <= 1'b0;
		end else begin
			mode_m_q <= prog_mode_pin;
			mode_s_q <= mode_m_q;
		end
	end

	// store updates: only the synced mode opens the path
	always_comb begin
		nv0_d = nv0_q;
		nv1_d = nv1_q;
		st_d = st_q;
		rdata_d = rdata_q;
		unique case (st_q)
			OBC_IDLE: begin
				if (mode_s_q && prog_erase && !nv0_q[B0_WLOCK]) begin // (RQ1) (RQ9)
					if (nv0_q[B0_RDP]) begin
						st_d = OBC_WIPE; // (RQ8)
					end else begin
						nv0_d = CFG0_RESET;
						nv1_d = CFG1_RESET;
					end
				end else if (mode_s_q && prog_wr && !prog_erase) begin // (RQ1)
					if (prog_sel == SEL_CFG1) begin
						nv1_d = prog_wdata; // (RQ15)
					end else if (!nv0_q[B0_WLOCK]) begin
						nv0_d = prog_wdata; // (RQ9)
					end
				end
				if (mode_s_q && prog_rd) begin
					rdata_d = (prog_sel == SEL_CFG1) ? nv1_q : nv0_q;
				end else begin
					rdata_d = 8'h00;
				end
			end
			OBC_WIPE: begin
				// option bytes cleared only after memory reports wiped
				rdata_d = 8'h00;
				if (mem_erase_done) begin // (RQ8)
					nv0_d = CFG0_RESET;
					nv1_d = CFG1_RESET;
					st_d = OBC_IDLE;
				end
			end
		endcase
	end

	// the store survives ordinary resets, only power-on restores defaults
	always_ff @(posedge clk) begin
		if (pwr_on_rst) begin
			nv0_q <= CFG0_RESET;
			nv1_q <= CFG1_RESET;
		end else begin
			nv0_q <= nv0_d;
			nv1_q <= nv1_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || pwr_on_rst) begin
			st_q <= OBC_IDLE;
			rdata_q <= 8'h00;
		end else begin
			st_q <= st_d;
			rdata_q <= rdata_d;
		end
	end

	obc_decode u_dec (
		.byte0(nv0_q),
		.byte1(nv1_q),
		.clk_src(dec_src),
		.vd_level(dec_vd)
	);

	// capture on the first edge after reset release, frozen afterwards
	always_comb begin
		load_d = 1'b0;
		valid_d = valid_q || load_q;
		act0_d = act0_q;
		act1_d = act1_q;
		src_d = src_q;
		vd_d = vd_q;
		if (load_q) begin // (RQ14)
			act0_d = nv0_q;
			act1_d = nv1_q;
			src_d = dec_src;
			vd_d = dec_vd;
		end
	end

	// strap-like capture: reset gives constants, the load happens after
	always_ff @(posedge clk) begin
		if (rst) begin
			load_q <= 1'b1;
			valid_q <= 1'b0;
			act0_q <= CFG0_RESET;
			act1_q <= CFG1_RESET;
			src_q <= OBC_CLK_RC;
			vd_q <= OBC_VD_OFF;
		end else begin
			load_q <= load_d;
			valid_q <= valid_d;
			act0_q <= act0_d;
			act1_q <= act1_d;
			src_q <= src_d;
			vd_q <= vd_d;
		end
	end

	// applied settings from captured flops, blank fill is a constant
	assign clk_src = src_q; // (RQ3) (RQ4)
	assign voltage_detect_threshold = vd_q; // (RQ11)
	assign boot_sector_size = act0_q[B0_SEC_HI:B0_SEC_LO]; // (RQ6)
	assign readout_protect = act0_q[B0_RDP]; // (RQ7)
	assign program_write_lock = act0_q[B0_WLOCK]; // (RQ9)
	// read-out protection also forbids program memory writes
	assign prog_mem_write_block = act0_q[B0_RDP] | act0_q[B0_WLOCK]; // (RQ7)
	assign pll_factor_sel = act1_q[B1_PLLF]; // (RQ15)
	assign pll_bypass = act1_q[B1_PLL_BYPASS];
	assign fast_pll_bypass = act1_q[B1_FAST_PLL_BYPASS];
	assign watchdog_type_sel = act1_q[B1_WDT]; // (RQ12)
	assign watchdog_halt_reset = act1_q[B1_WDHALT]; // (RQ13)
	assign blank_fill = BLANK_BYTE; // (RQ10)
	assign cfg_valid = valid_q;
	assign prog_rdata = rdata_q;
	assign prog_busy = (st_q == OBC_WIPE);
	assign mem_erase_req = (st_q == OBC_WIPE); // (RQ8)

	// assertion helpers
	// a reset landing on the request edge cancels it, so it is left out
	sequence s_erase_protected;
		mode_s_q && prog_erase && !nv0_q[B0_WLOCK] && nv0_q[B0_RDP] && st_q == OBC_IDLE
			&& !rst;
	endsequence
	// one waiting cycle: wipe requested, port busy, store untouched
	sequence s_wipe_wait;
		mem_erase_req && prog_busy && $stable(nv0_q) && $stable(nv1_q);
	endsequence

	property p_no_change_outside_mode;
		@(posedge clk) disable iff (rst || pwr_on_rst)
		!mode_s_q && st_q == OBC_IDLE |=> $stable(nv0_q) && $stable(nv1_q);
	endproperty
	a_no_change_outside_mode: assert property (p_no_change_outside_mode) // (RQ1)
		else $error("config bytes changed outside programming mode");

	property p_lock_freezes_byte0;
		@(posedge clk) disable iff (rst || pwr_on_rst)
		nv0_q[B0_WLOCK] |=> $stable(nv0_q);
	endproperty
	a_lock_freezes_byte0: assert property (p_lock_freezes_byte0) // (RQ9)
		else $error("locked first byte was altered");

	property p_protected_erase_wipes_first;
		@(posedge clk) disable iff (rst || pwr_on_rst)
		s_erase_protected |=> s_wipe_wait;
	endproperty
	a_protected_erase_wipes_first: assert property (p_protected_erase_wipes_first) // (RQ8)
		else $error("protected erase skipped memory wipe");

	// the wait lasts as long as memory needs, so it is checked step by step
	property p_wipe_held_until_done;
		@(posedge clk) disable iff (rst || pwr_on_rst)
		mem_erase_req && !mem_erase_done && !rst |=> s_wipe_wait;
	endproperty
	a_wipe_held_until_done: assert property (p_wipe_held_until_done) // (RQ8)
		else $error("wipe request dropped before memory reported done");

	property p_wipe_then_defaults;
		@(posedge clk) disable iff (rst || pwr_on_rst)
		mem_erase_req && mem_erase_done |=> nv0_q == CFG0_RESET && !mem_erase_req;
	endproperty
	a_wipe_then_defaults: assert property (p_wipe_then_defaults) // (RQ8)
		else $error("bytes not defaulted after memory wipe");

	property p_load_after_reset;
		@(posedge clk) disable iff (rst)
		$fell(load_q) |-> cfg_valid && act0_q == $past(nv0_q) && act1_q == $past(nv1_q);
	endproperty
	a_load_after_reset: assert property (p_load_after_reset) // (RQ14)
		else $error("settings not captured after reset");

	property p_settings_held;
		@(posedge clk) disable iff (rst)
		cfg_valid && !rst |=> $stable(act0_q) && $stable(act1_q) && $stable(clk_src);
	endproperty
	a_settings_held: assert property (p_settings_held) // (RQ14)
		else $error("applied settings changed without reset");

	property p_rc_ignores_range;
		@(posedge clk) disable iff (rst)
		cfg_valid && !act1_q[B1_RCSEL] |-> clk_src == OBC_CLK_RC;
	endproperty
	a_rc_ignores_range: assert property (p_rc_ignores_range) // (RQ3)
		else $error("range field used while rc selected");

	property p_ext_pin_code;
		@(posedge clk) disable iff (rst)
		cfg_valid && act1_q[B1_RCSEL] && act0_q[B0_OSC_HI:B0_OSC_LO] == OSC_EXT_ALT
			|-> clk_src == OBC_CLK_EXT_ALT_PIN;
	endproperty
	a_ext_pin_code: assert property (p_ext_pin_code) // (RQ4)
		else $error("alternate pin clock code misdecoded");

	property p_lvd_off;
		@(posedge clk) disable iff (rst)
		cfg_valid && act1_q[B1_LVD_HI:B1_LVD_LO] == LVD_OFF |-> voltage_detect_threshold == OBC_VD_OFF;
	endproperty
	a_lvd_off: assert property (p_lvd_off) // (RQ11)
		else $error("voltage detect not off for code 11");

	property p_write_block;
		@(posedge clk) disable iff (rst)
		readout_protect || program_write_lock |-> prog_mem_write_block;
	endproperty
	a_write_block: assert property (p_write_block) // (RQ7)
		else $error("program memory writes not blocked");
endmodule : obc_top

// ---- shared/obc_pkg.sv ----
// option byte configuration: shared constants and types
package obc_pkg;
	localparam int unsigned BYTE_W = 8;
	localparam logic [7:0] CFG0_RESET = 8'hfc;
	localparam logic [7:0] CFG1_RESET = 8'hef;
	localparam logic [7:0] BLANK_BYTE = 8'hff;
	// byte select on the programming port
	localparam logic SEL_CFG0 = 1'b0;
	localparam logic SEL_CFG1 = 1'b1;
	// first configuration byte fields
	localparam int unsigned B0_RSVD = 7;
	localparam int unsigned B0_OSC_HI = 6;
	localparam int unsigned B0_OSC_LO = 4;
	localparam int unsigned B0_SEC_HI = 3;
	localparam int unsigned B0_SEC_LO = 2;
	localparam int unsigned B0_RDP = 1;
	localparam int unsigned B0_WLOCK = 0;
	// second configuration byte fields
	localparam int unsigned B1_PLLF = 7;
	localparam int unsigned B1_PLL_BYPASS = 6;
	localparam int unsigned B1_FAST_PLL_BYPASS = 5;
	localparam int unsigned B1_RCSEL = 4;
	localparam int unsigned B1_LVD_HI = 3;
	localparam int unsigned B1_LVD_LO = 2;
	localparam int unsigned B1_WDT = 1;
	localparam int unsigned B1_WDHALT = 0;
	// oscillator range codes
	localparam logic [2:0] OSC_LP = 3'h0;
	localparam logic [2:0] OSC_MP = 3'h1;
	localparam logic [2:0] OSC_MS = 3'h2;
	localparam logic [2:0] OSC_HS = 3'h3;
	localparam logic [2:0] OSC_VLP = 3'h4;
	localparam logic [2:0] OSC_EXT_PIN = 3'h5;
	localparam logic [2:0] OSC_RSVD = 3'h6;
	localparam logic [2:0] OSC_EXT_ALT = 3'h7;
	// voltage detect codes
	localparam logic [1:0] LVD_LOW = 2'h0;
	localparam logic [1:0] LVD_MED = 2'h1;
	localparam logic [1:0] LVD_HIGH = 2'h2;
	localparam logic [1:0] LVD_OFF = 2'h3;
	typedef enum logic [3:0] {
		OBC_CLK_RC,
		OBC_CLK_RES_1_2M,
		OBC_CLK_RES_2_4M,
		OBC_CLK_RES_4_8M,
		OBC_CLK_RES_8_16M,
		OBC_CLK_RES_32K,
		OBC_CLK_EXT_OSC_PIN,
		OBC_CLK_EXT_ALT_PIN,
		OBC_CLK_RESERVED
	} obc_clk_src_t;
	typedef enum logic [1:0] {
		OBC_VD_OFF,
		OBC_VD_HIGH,
		OBC_VD_MED,
		OBC_VD_LOW
	} obc_vd_t;
endpackage : obc_pkg

// ---- test/obc_mem_model.sv ----
// program memory wipe responder facing the erase handshake
module obc_mem_model #(
	parameter int DELAY = 6
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic mem_erase_req,
	output logic mem_erase_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// a real wipe takes time, so done comes late and only once
	always_ff @(posedge clk) begin
		if (rst || !mem_erase_req) begin
			cnt <= 0;
			mem_erase_done <= 1'b0;
		end else begin
			cnt <= cnt + 1;
			mem_erase_done <= (cnt == DELAY - 1);
		end
	end
endmodule : obc_mem_model

// ---- test/obc_top_tb.sv ----
// bench for the configuration byte store and its decode
module obc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import obc_pkg::*;
	logic clk, rst, por, mode, wr, rd, er, sel, done;
	logic busy, req, rdp, wl, wb, pf, pb, fb, wt, wh, valid;
	logic [7:0] wd, rdata, blank, b0, b1;
	logic [1:0] sec;
	obc_clk_src_t src;
	obc_vd_t vd;
	int err_count = 0;
	int tests_run = 0;
	obc_clk_src_t src_tab [8] = '{OBC_CLK_RES_1_2M, OBC_CLK_RES_2_4M, OBC_CLK_RES_4_8M,
		OBC_CLK_RES_8_16M, OBC_CLK_RES_32K, OBC_CLK_EXT_OSC_PIN, OBC_CLK_RESERVED,
		OBC_CLK_EXT_ALT_PIN};
	obc_vd_t vd_tab [4] = '{OBC_VD_LOW, OBC_VD_MED, OBC_VD_HIGH, OBC_VD_OFF};
	obc_top i_dut (.clk(clk), .rst(rst), .pwr_on_rst(por), .prog_mode_pin(mode),
		.prog_wr(wr), .prog_rd(rd), .prog_erase(er), .prog_sel(sel), .prog_wdata(wd),
		.prog_rdata(rdata), .prog_busy(busy), .mem_erase_req(req), .mem_erase_done(done),
		.clk_src(src), .boot_sector_size(sec), .readout_protect(rdp),
		.program_write_lock(wl), .prog_mem_write_block(wb), .pll_factor_sel(pf),
		.pll_bypass(pb), .fast_pll_bypass(fb), .voltage_detect_threshold(vd),
		.watchdog_type_sel(wt), .watchdog_halt_reset(wh), .blank_fill(blank),
		.cfg_valid(valid));
	obc_mem_model #(.DELAY(6)) i_mem (.clk(clk), .rst(rst), .mem_erase_req(req),
		.mem_erase_done(done));
	// free running bench clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic final_report;
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one strobe cycle; read data is settled when this returns
	task automatic pulse(input logic w, input logic r, input logic e, input logic s,
		input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		er <= e;
		sel <= s;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		er <= 1'b0;
		#1;
	endtask : pulse
	task automatic rd_check(input string what, input logic s, input logic [7:0] exp);
		pulse(1'b0, 1'b1, 1'b0, s, 8'h00);
		check(what, rdata, exp);
	endtask : rd_check
	// settings are only taken up at reset, mode sync needs fresh edges after
	task automatic app_rst;
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : app_rst
	task automatic applied(input logic [7:0] c0, input logic [7:0] c1);
		check("src", {4'h0, src}, {4'h0, c1[B1_RCSEL] ? src_tab[c0[6:4]] : OBC_CLK_RC});
		check("sector", {6'h0, sec}, {6'h0, c0[3:2]});
		check("prot", {6'h0, rdp, wl}, {6'h0, c0[1:0]});
		check("wblock", {7'h0, wb}, {7'h0, |c0[1:0]});
		check("b1bits", {3'h0, pf, pb, fb, wt, wh}, {3'h0, c1[7:5], c1[1:0]});
		check("vdet", {6'h0, vd}, {6'h0, vd_tab[c1[3:2]]});
		check("blank", blank, 8'hff);
		check("valid", {7'h0, valid}, 8'h01);
	endtask : applied
	task automatic wait_idle;
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			#1;
			if (busy === 1'b0) return;
		end
		err_count++;
		final_report;
	endtask : wait_idle
	// main sequence, the programmer role is played here
	initial begin
		{rst, por} = 2'b11;
		{mode, wr, rd, er, sel} = 5'h00;
		wd = 8'h00;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		applied(CFG0_RESET, CFG1_RESET);
		pulse(1'b1, 1'b0, 1'b0, SEL_CFG1, 8'h00);
		rd_check("rd_off", SEL_CFG1, 8'h00);
		@(posedge clk);
		mode <= 1'b1;
		repeat (3) @(posedge clk);
		rd_check("b1_kept", SEL_CFG1, CFG1_RESET);
		// every range and threshold code with rc off
		for (int i = 0; i < 8; i++) begin
			b0 = {1'b1, i[2:0], i[1:0], 2'b00};
			b1 = {i[2:0], 1'b1, i[1:0], i[0], ~i[0]};
			pulse(1'b1, 1'b0, 1'b0, SEL_CFG0, b0);
			pulse(1'b1, 1'b0, 1'b0, SEL_CFG1, b1);
			rd_check("b0_rd", SEL_CFG0, b0);
			if (i == 0) applied(CFG0_RESET, CFG1_RESET);
			app_rst();
			applied(b0, b1);
		end
		// unprotected erase restores defaults at once, no wipe
		pulse(1'b0, 1'b0, 1'b1, SEL_CFG0, 8'h00);
		check("plain_erase", {6'h0, req, busy}, 8'h00);
		rd_check("b1_erased", SEL_CFG1, CFG1_RESET);
		// rc on with range left at default, then read-out protection
		pulse(1'b1, 1'b0, 1'b0, SEL_CFG0, 8'hfa);
		pulse(1'b1, 1'b0, 1'b0, SEL_CFG1, 8'he3);
		app_rst();
		applied(8'hfa, 8'he3);
		pulse(1'b0, 1'b0, 1'b1, SEL_CFG0, 8'h00);
		check("wipe", {6'h0, req, busy}, 8'h03);
		wait_idle();
		rd_check("b0_wiped", SEL_CFG0, CFG0_RESET);
		rd_check("b1_wiped", SEL_CFG1, CFG1_RESET);
		applied(8'hfa, 8'he3);
		// permanent lock freezes the first byte
		pulse(1'b1, 1'b0, 1'b0, SEL_CFG0, 8'hf9);
		app_rst();
		applied(8'hf9, CFG1_RESET);
		pulse(1'b1, 1'b0, 1'b0, SEL_CFG0, 8'hf8);
		pulse(1'b0, 1'b0, 1'b1, SEL_CFG0, 8'h00);
		check("no_wipe", {6'h0, req, busy}, 8'h00);
		rd_check("b0_locked", SEL_CFG0, 8'hf9);
		final_report();
	end
endmodule : obc_top_tb
